// File: dss_top.sv
`timescale 1ns/1ps
// Functional notes
// - Selector one drives motion and action status bit 9; codes 1,2 current, velocity.
// - Codes 3,4 deviation windows; codes 5 to 8 position register channels 1 to 4.
// - Code 9 hardware limit, 10 relative move after capture, 11 position window.
// - Selector two drives drive status bit 11 and motion status bit 10.
// - All four settings act immediately after a write.
// - Transition setting 0 moves switch-on-disabled to ready-to-switch-on automatically.
// - Transition setting 1 waits in state 3 for the master's command.
// - Transition setting is changed only while the power stage is disabled.
// - Shutdown option 0 disables the power stage at once during movement.
// - Shutdown option 1 halts to standstill first, then disables.
module dss_top (
  input wire logic clk,
  input wire logic nrst,
  input wire dss_pkg::dss_req_t req,
  output logic [31:0] rdata_r,
  output logic ack_r,
  output logic err_r,
  input wire logic [15:0] drive_control_word,
  input wire logic disable_req,
  input wire logic standstill,
  input wire dss_pkg::dss_cond_t conds_async,
  output logic [15:0] motion_status_word_r,
  output logic [15:0] action_status_word_r,
  output logic [15:0] drive_status_word_r,
  output logic power_stage_on_r,
  output logic halt_active_r,
  output logic [3:0] state_num_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Condition synchroniser: the conditions come from other logic and pins.

  dss_pkg::dss_cond_t sync1_r, sync2_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= conds_async;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers.

  logic [15:0] shutdown_r, shutdown_nxt;
  logic [15:0] transition_r, transition_nxt;
  logic [15:0] stat_lim_r, stat_lim_nxt;
  logic [15:0] mot_lim_r, mot_lim_nxt;
  logic [15:0] ref_a_r, ref_a_nxt;
  logic [31:0] ref_b_r, ref_b_nxt;
  logic [31:0] rdata_nxt;
  logic ack_nxt, err_nxt;

  function automatic logic sel_ok(input logic [31:0] v);
    sel_ok = (v[31:16] == 16'h0000) && (v[15:0] <= dss_pkg::SEL_MAX);
  endfunction

  always_comb begin
    shutdown_nxt = shutdown_r;
    transition_nxt = transition_r;
    stat_lim_nxt = stat_lim_r;
    mot_lim_nxt = mot_lim_r;
    ref_a_nxt = ref_a_r;
    ref_b_nxt = ref_b_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (req.wr) begin
      ack_nxt = 1'b1;
      case (req.addr)
        dss_pkg::ADDR_SHUTDOWN: begin
          if (req.wdata[15:1] == 15'h0000) shutdown_nxt = req.wdata[15:0];
          else err_nxt = 1'b1;
        end
        dss_pkg::ADDR_TRANSITION: begin
          // Refused while the power stage is on so the state machine never sees
          // its entry condition change under it.
          if (!power_stage_on_r && req.wdata[15:1] == 15'h0000) begin
            transition_nxt = req.wdata[15:0];
          end else begin
            err_nxt = 1'b1;
          end
        end
        dss_pkg::ADDR_STAT_LIM: begin
          if (sel_ok(req.wdata)) stat_lim_nxt = req.wdata[15:0];
          else err_nxt = 1'b1;
        end
        dss_pkg::ADDR_MOT_LIM: begin
          if (sel_ok(req.wdata)) mot_lim_nxt = req.wdata[15:0];
          else err_nxt = 1'b1;
        end
        dss_pkg::ADDR_REF_A: ref_a_nxt = req.wdata[15:0];
        dss_pkg::ADDR_REF_B: ref_b_nxt = req.wdata;
        default: err_nxt = 1'b1;
      endcase
    end else if (req.rd) begin
      ack_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      case (req.addr)
        dss_pkg::ADDR_SHUTDOWN: rdata_nxt = {16'h0000, shutdown_r};
        dss_pkg::ADDR_TRANSITION: rdata_nxt = {16'h0000, transition_r};
        dss_pkg::ADDR_STAT_LIM: rdata_nxt = {16'h0000, stat_lim_r};
        dss_pkg::ADDR_MOT_LIM: rdata_nxt = {16'h0000, mot_lim_r};
        dss_pkg::ADDR_REF_A: rdata_nxt = {16'h0000, ref_a_r};
        dss_pkg::ADDR_REF_B: rdata_nxt = ref_b_r;
        default: err_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shutdown_r <= dss_pkg::RST_SHUTDOWN;
      transition_r <= dss_pkg::RST_TRANSITION;
      stat_lim_r <= dss_pkg::RST_STAT_LIM;
      mot_lim_r <= dss_pkg::RST_MOT_LIM;
      ref_a_r <= 16'h0000;
      ref_b_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      shutdown_r <= shutdown_nxt;
      transition_r <= transition_nxt;
      stat_lim_r <= stat_lim_nxt;
      mot_lim_r <= mot_lim_nxt;
      ref_a_r <= ref_a_nxt;
      ref_b_r <= ref_b_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bit routing.

  logic lim1_bit, lim2_bit;

  dss_cond_mux u_mux_mot (
    .sel(mot_lim_r),
    .conds(sync2_r),
    .bit_out(lim1_bit)
  );

  dss_cond_mux u_mux_stat (
    .sel(stat_lim_r),
    .conds(sync2_r),
    .bit_out(lim2_bit)
  );

  logic [15:0] mot_nxt, act_nxt, drv_nxt;

  always_comb begin
    mot_nxt = 16'h0000;
    act_nxt = 16'h0000;
    drv_nxt = 16'h0000;
    mot_nxt[dss_pkg::BIT_MOT_LIM1] = lim1_bit;
    act_nxt[dss_pkg::BIT_ACT_LIM1] = lim1_bit;
    drv_nxt[dss_pkg::BIT_DRV_LIM2] = lim2_bit;
    mot_nxt[dss_pkg::BIT_MOT_LIM2] = lim2_bit;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motion_status_word_r <= 16'h0000;
      action_status_word_r <= 16'h0000;
      drive_status_word_r <= 16'h0000;
    end else begin
      motion_status_word_r <= mot_nxt;
      action_status_word_r <= act_nxt;
      drive_status_word_r <= drv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine (reduced to the transitions this block steers).

  dss_pkg::dss_state_t st_r, st_nxt;
  logic cw_qs, cw_en, cw_halt;
  logic pwr_nxt, halt_nxt;
  logic [3:0] num_nxt;

  assign cw_qs = drive_control_word[dss_pkg::CW_QUICK_STOP];
  assign cw_en = drive_control_word[dss_pkg::CW_ENABLE_OP];
  assign cw_halt = drive_control_word[dss_pkg::CW_HALT];

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dss_pkg::SM_SOD: begin
        // Automatic mode leaves at once; compliant mode waits for the master.
        if (transition_r[0] == 1'b0 || cw_qs) st_nxt = dss_pkg::SM_RTSO;
      end
      dss_pkg::SM_RTSO: begin
        if (cw_en) st_nxt = dss_pkg::SM_ON;
      end
      dss_pkg::SM_ON: begin
        if (disable_req || !cw_en) begin
          if (shutdown_r[0] && !standstill) st_nxt = dss_pkg::SM_HALTING;
          else st_nxt = dss_pkg::SM_SOD;
        end
      end
      dss_pkg::SM_HALTING: begin
        if (standstill) st_nxt = dss_pkg::SM_SOD;
      end
      default: st_nxt = dss_pkg::SM_SOD;
    endcase
    // The power stage stays on through halting so the axis is braked under control.
    pwr_nxt = (st_nxt == dss_pkg::SM_ON) || (st_nxt == dss_pkg::SM_HALTING);
    halt_nxt = (st_nxt == dss_pkg::SM_HALTING) || cw_halt;
    case (st_nxt)
      dss_pkg::SM_SOD: num_nxt = dss_pkg::ST_NUM_SOD;
      dss_pkg::SM_RTSO: num_nxt = dss_pkg::ST_NUM_RTSO;
      dss_pkg::SM_ON: num_nxt = dss_pkg::ST_NUM_ON;
      default: num_nxt = dss_pkg::ST_NUM_HALTING;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= dss_pkg::SM_SOD;
      power_stage_on_r <= 1'b0;
      halt_active_r <= 1'b0;
      state_num_r <= dss_pkg::ST_NUM_SOD;
    end else begin
      st_r <= st_nxt;
      power_stage_on_r <= pwr_nxt;
      halt_active_r <= halt_nxt;
      state_num_r <= num_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_auto_transition: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_SOD && transition_r[0] == 1'b0) |=> st_r == dss_pkg::SM_RTSO)
    else $error("automatic transition to ready state missing");
  a_wait_command: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_SOD && transition_r[0] && !cw_qs) |=> st_r == dss_pkg::SM_SOD)
    else $error("left state 3 without command");
  a_trans_locked: assert property (@(posedge clk) disable iff (!nrst)
    power_stage_on_r |=> $stable(transition_r))
    else $error("transition setting changed with power stage on");
  a_immediate_off: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_ON && disable_req && !shutdown_r[0]) |=> !power_stage_on_r)
    else $error("power stage not disabled at once");
  a_halt_first: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_ON && disable_req && shutdown_r[0] && !standstill)
      |=> power_stage_on_r && halt_active_r)
    else $error("power stage disabled before halt");
  a_halt_hold: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_HALTING && !standstill) |=> power_stage_on_r && halt_active_r)
    else $error("power stage dropped before standstill");
  a_halt_release: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_HALTING && standstill)
      |=> !power_stage_on_r && st_r == dss_pkg::SM_SOD)
    else $error("power stage stayed on at standstill");
  a_enable_op: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == dss_pkg::SM_RTSO && cw_en) |=> power_stage_on_r)
    else $error("enable command ignored");
  a_lim1_route: assert property (@(posedge clk) disable iff (!nrst)
    ##1 motion_status_word_r[dss_pkg::BIT_MOT_LIM1] == $past(lim1_bit)
      && action_status_word_r[dss_pkg::BIT_ACT_LIM1] == $past(lim1_bit))
    else $error("bit 9 routing wrong");
  a_lim2_route: assert property (@(posedge clk) disable iff (!nrst)
    (stat_lim_r == 16'h0000) |=> !drive_status_word_r[dss_pkg::BIT_DRV_LIM2])
    else $error("reserved selector drove status bit");
  a_lim2_pair: assert property (@(posedge clk) disable iff (!nrst)
    motion_status_word_r[dss_pkg::BIT_MOT_LIM2]
      == drive_status_word_r[dss_pkg::BIT_DRV_LIM2])
    else $error("selector two bits disagree");
  a_sel_reject: assert property (@(posedge clk) disable iff (!nrst)
    (req.wr && req.addr == dss_pkg::ADDR_MOT_LIM && req.wdata > 32'h0000_000B)
      |=> $stable(mot_lim_r) && err_r)
    else $error("out-of-range selector accepted");
  a_write_apply: assert property (@(posedge clk) disable iff (!nrst)
    (req.wr && req.addr == dss_pkg::ADDR_STAT_LIM && req.wdata <= 32'h0000_000B)
      |=> {16'h0000, stat_lim_r} == $past(req.wdata))
    else $error("selector write not applied");
  a_access_ack: assert property (@(posedge clk) disable iff (!nrst)
    (req.wr || req.rd) |=> ack_r)
    else $error("access not acknowledged");

  c_enable: cover property (@(posedge clk) disable iff (!nrst) st_r == dss_pkg::SM_ON);
  c_halting: cover property (@(posedge clk) disable iff (!nrst) st_r == dss_pkg::SM_HALTING);
  c_reject: cover property (@(posedge clk) disable iff (!nrst) err_r);
  c_wait_cmd: cover property (@(posedge clk) disable iff (!nrst)
    st_r == dss_pkg::SM_SOD && transition_r[0]);
  c_route_high: cover property (@(posedge clk) disable iff (!nrst)
    drive_status_word_r[dss_pkg::BIT_DRV_LIM2]);

endmodule

// File: dss_pkg.sv
package dss_pkg;

  // Parameter addresses as reached over the fieldbus parameter channel.
  localparam logic [15:0] ADDR_SHUTDOWN = 16'h0694;
  localparam logic [15:0] ADDR_TRANSITION = 16'h1B26;
  localparam logic [15:0] ADDR_STAT_LIM = 16'h1B3C;
  localparam logic [15:0] ADDR_REF_B = 16'h1B42;
  localparam logic [15:0] ADDR_REF_A = 16'h1B44;
  localparam logic [15:0] ADDR_MOT_LIM = 16'h1B6A;

  localparam logic [15:0] RST_SHUTDOWN = 16'h0000;
  localparam logic [15:0] RST_TRANSITION = 16'h0000;
  localparam logic [15:0] RST_STAT_LIM = 16'h0000;
  localparam logic [15:0] RST_MOT_LIM = 16'h000B;

  localparam logic [15:0] SEL_MAX = 16'h000B;
  localparam int NUM_COND = 12;

  // Status word bit positions.
  localparam int BIT_MOT_LIM1 = 9;
  localparam int BIT_ACT_LIM1 = 9;
  localparam int BIT_DRV_LIM2 = 11;
  localparam int BIT_MOT_LIM2 = 10;

  // Control word bit positions.
  localparam int CW_QUICK_STOP = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_HALT = 8;

  // Power-state machine state numbers as reported.
  localparam logic [3:0] ST_NUM_SOD = 4'h3;
  localparam logic [3:0] ST_NUM_RTSO = 4'h4;
  localparam logic [3:0] ST_NUM_ON = 4'h6;
  localparam logic [3:0] ST_NUM_HALTING = 4'h7;

  typedef enum logic [2:0] {
    SM_SOD,
    SM_RTSO,
    SM_ON,
    SM_HALTING
  } dss_state_t;

  // Parameter access request from the fieldbus side.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dss_req_t;

  // Condition inputs, indexed by selector code (bit 0 unused).
  typedef struct packed {
    logic [NUM_COND-1:0] cond;
  } dss_cond_t;

endpackage

// File: dss_cond_mux.sv
`timescale 1ns/1ps
module dss_cond_mux (
  input wire logic [15:0] sel,
  input wire dss_pkg::dss_cond_t conds,
  output logic bit_out
);

  always_comb begin
    bit_out = 1'b0;
    // Code 0 is reserved and forced to zero; codes 1..11 pick their condition.
    if (sel != 16'h0000 && sel <= dss_pkg::SEL_MAX) begin
      bit_out = conds.cond[sel[3:0]];
    end
  end

endmodule

// File: dss_master.sv
`timescale 1ns/1ps
module dss_master (
  input wire logic clk,
  input wire logic ack_r,
  input wire logic err_r,
  input wire logic [31:0] rdata_r,
  output dss_pkg::dss_req_t req,
  output logic [15:0] drive_control_word
);
  initial begin
    req = '0;
    drive_control_word = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Released lines carry the inverse, so a stale address is never mistaken for a live one.
  task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [1:0] r, output logic [31:0] q);
    @(posedge clk);
    req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clk);
    r = {ack_r, err_r};
    q = rdata_r;
  endtask
  // Halt, quick stop, enable and leaving state 3 are all commanded here.
  task automatic ctrl(input logic [15:0] v);
    @(posedge clk);
    drive_control_word <= v;
  endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, disable_req, standstill, ack_r, err_r, pwr, halt;
  dss_pkg::dss_req_t req;
  dss_pkg::dss_cond_t conds;
  logic [15:0] dcw, msw, asw, dsw;
  logic [31:0] rdata_r, q;
  logic [3:0] st;
  logic [1:0] rsp;
  int n_errors = 0;
  int cmp_count = 0;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  dss_top u_dut (.clk(clk), .nrst(nrst), .req(req), .rdata_r(rdata_r), .ack_r(ack_r),
    .err_r(err_r), .drive_control_word(dcw), .disable_req(disable_req),
    .standstill(standstill), .conds_async(conds), .motion_status_word_r(msw),
    .action_status_word_r(asw), .drive_status_word_r(dsw), .power_stage_on_r(pwr),
    .halt_active_r(halt), .state_num_r(st));
  dss_master u_master (.clk(clk), .ack_r(ack_r), .err_r(err_r), .rdata_r(rdata_r),
    .req(req), .drive_control_word(dcw));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] exp);
    u_master.access(1'b1, a, d, rsp, q);
    chk("write response", 32'(rsp), 32'(exp));
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    u_master.access(1'b0, a, 32'h0, rsp, q);
    chk("read response", 32'(rsp), 32'h2);
    chk("read data", q, exp);
  endtask
  task automatic chk_st(input logic [3:0] s, input logic p);
    chk("state", 32'(st), 32'(s));
    chk("power stage", 32'(pwr), 32'(p));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(dss_pkg::ADDR_SHUTDOWN, 32'h0);
    rd(dss_pkg::ADDR_TRANSITION, 32'h0);
    rd(dss_pkg::ADDR_STAT_LIM, 32'h0);
    rd(dss_pkg::ADDR_MOT_LIM, 32'hB);
    wr(16'h0000, 32'h1, 2'b11);
    // The reference words are plain storage; the short one zero-extends on read.
    wr(dss_pkg::ADDR_REF_B, 32'hA5C3_0F96, 2'b10);
    rd(dss_pkg::ADDR_REF_B, 32'hA5C3_0F96);
    wr(dss_pkg::ADDR_REF_A, 32'hFFFF_1234, 2'b10);
    rd(dss_pkg::ADDR_REF_A, 32'h0000_1234);
    chk_st(4'h4, 1'b0);
    $display("test reset done");
  endtask
  // Selector two sits five codes away, so a swapped or shared selector shows up.
  task automatic route(input int c, input int c2, input logic [11:0] p);
    logic e1, e2;
    e1 = (c != 0) && p[c];
    e2 = (c2 != 0) && p[c2];
    @(posedge clk);
    conds <= '{cond: p};
    cyc(5);
    chk("motion word", 32'(msw), 32'({e2, e1, 9'h000}));
    chk("action word", 32'(asw), 32'({e1, 9'h000}));
    chk("drive word", 32'(dsw), 32'({e2, 11'h000}));
  endtask
  task automatic t_sel;
    for (int c = 0; c < 12; c++) begin
      wr(dss_pkg::ADDR_MOT_LIM, 32'(c), 2'b10);
      wr(dss_pkg::ADDR_STAT_LIM, 32'((c + 5) % 12), 2'b10);
      route(c, (c + 5) % 12, 12'(1 << c));
      route(c, (c + 5) % 12, ~12'(1 << c));
    end
    wr(dss_pkg::ADDR_MOT_LIM, 32'hC, 2'b11);
    rd(dss_pkg::ADDR_MOT_LIM, 32'hB);
    wr(dss_pkg::ADDR_STAT_LIM, 32'hFFFF, 2'b11);
    rd(dss_pkg::ADDR_STAT_LIM, 32'h4);
    $display("test selectors done");
  endtask
  task automatic t_trans;
    wr(dss_pkg::ADDR_TRANSITION, 32'h2, 2'b11);
    rd(dss_pkg::ADDR_TRANSITION, 32'h0);
    wr(dss_pkg::ADDR_TRANSITION, 32'h1, 2'b10);
    u_master.ctrl(16'h0008);
    cyc(4);
    chk_st(4'h6, 1'b1);
    wr(dss_pkg::ADDR_TRANSITION, 32'h0, 2'b11);
    rd(dss_pkg::ADDR_TRANSITION, 32'h1);
    disable_req <= 1'b1;
    cyc(2);
    chk_st(4'h3, 1'b0);
    u_master.ctrl(16'h0000);
    disable_req <= 1'b0;
    cyc(8);
    chk_st(4'h3, 1'b0);
    u_master.ctrl(16'h0004);
    cyc(3);
    chk_st(4'h4, 1'b0);
    $display("test transition done");
  endtask
  task automatic t_shut;
    wr(dss_pkg::ADDR_SHUTDOWN, 32'h1, 2'b10);
    wr(dss_pkg::ADDR_SHUTDOWN, 32'h2, 2'b11);
    rd(dss_pkg::ADDR_SHUTDOWN, 32'h1);
    standstill <= 1'b0;
    u_master.ctrl(16'h0008);
    cyc(4);
    chk_st(4'h6, 1'b1);
    disable_req <= 1'b1;
    cyc(4);
    chk_st(4'h7, 1'b1);
    chk("halt", 32'(halt), 32'h1);
    standstill <= 1'b1;
    cyc(3);
    chk_st(4'h3, 1'b0);
    u_master.ctrl(16'h0100);
    disable_req <= 1'b0;
    cyc(3);
    chk("halt bit", 32'(halt), 32'h1);
    $display("test shutdown done");
  endtask
  // A reset in mid-run must bring back the reset settings and the automatic transition.
  task automatic t_rerun;
    @(posedge clk);
    nrst <= 1'b0;
    cyc(2);
    chk_st(4'h3, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    rd(dss_pkg::ADDR_MOT_LIM, 32'hB);
    rd(dss_pkg::ADDR_TRANSITION, 32'h0);
    rd(dss_pkg::ADDR_SHUTDOWN, 32'h0);
    chk_st(4'h4, 1'b0);
    $display("test second reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    disable_req = 1'b0;
    standstill = 1'b1;
    conds = '0;
    cyc(10);
    chk("state in reset", 32'(st), 32'h3);
    @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_sel;
    t_trans;
    t_shut;
    t_rerun;
    end_sim;
  end
  // Roughly ten times the cycles the tests need.
  initial begin
    #16000;
    n_errors++;
    end_sim;
  end
endmodule
